// ### core/buck_clk_pkg.sv
package buck_clk_pkg;

    // Wishbone byte offsets
    localparam logic [7:0] OFS_CTRL      = 8'h00;
    localparam logic [7:0] OFS_CLKCFG    = 8'h04;
    localparam logic [7:0] OFS_CONV0     = 8'h08;
    localparam logic [7:0] OFS_CONV1     = 8'h0c;
    localparam logic [7:0] OFS_GPO       = 8'h10;
    localparam logic [7:0] OFS_MEAS_SEL  = 8'h14;
    localparam logic [7:0] OFS_RESULT_LO = 8'h18;
    localparam logic [7:0] OFS_RESULT_HI = 8'h1c;
    localparam logic [7:0] OFS_FLAGS     = 8'h20;
    localparam logic [7:0] OFS_MASK      = 8'h24;
    localparam logic [7:0] OFS_STATUS    = 8'h28;

    // Field positions
    localparam int CTRL_EXT_SYNC   = 0;
    localparam int CTRL_SPREAD     = 1;
    localparam int CTRL_CONV_EN0   = 2;
    localparam int FLAG_MEAS       = 0;
    localparam int FLAG_SYNC       = 1;
    localparam int GPO_VAL1        = 0;
    localparam int GPO_VAL2        = 1;
    localparam int GPO_OD1         = 2;
    localparam int GPO_OD2         = 3;
    localparam int GPO_PIN_AS_SECOND_GENERAL_OUTPUT = 4;

    // Reset values
    localparam logic [3:0] CTRL_RESET   = 4'h0;
    localparam logic [4:0] FREQ_RESET   = 5'h01;
    localparam logic [4:0] GPO_RESET    = 5'h00;
    localparam logic [1:0] MASK_RESET   = 2'h0;

    // Timing
    localparam int CLK_MHZ          = 50;
    localparam int MEAS_MAX_US      = 50;
    localparam int MEAS_CYCLES      = MEAS_MAX_US * CLK_MHZ;
    localparam int DET_WINDOW_US    = 10;
    localparam int DET_CYCLES       = DET_WINDOW_US * CLK_MHZ;
    localparam int TOL_PERCENT      = 10;
    localparam int RC_HALF_NOM      = 6;
    localparam int RC_HALF_MIN      = 5;
    localparam int RC_HALF_MAX      = 7;
    localparam int FREQ_MIN_MHZ     = 1;
    localparam int FREQ_MAX_MHZ     = 24;

    typedef enum logic [1:0] {
        ST_POR,
        ST_OTP_LOAD,
        ST_STANDBY,
        ST_ACTIVE
    } pwr_state_t;

    typedef struct packed {
        logic [3:0] stop_delay;
        logic [3:0] start_delay;
        logic [2:0] slew;
        logic [1:0] ilim;
        logic       fpwm;
        logic [7:0] vout;
    } conv_cfg_t;

    typedef struct packed {
        logic       out;
        logic       oe;
    } pin_drive_t;

endpackage

// ### core/buck_sync_clock_and_load_meas.sv
// Design decisions made here: the Wishbone slave port and the placing of the registers.
`timescale 1ns/1ps
// Notes on behaviour
// RULE1: Writing the select register starts a measurement of the chosen converter.
// RULE2: Measured converter runs forced PWM during measurement, then normal mode.
// RULE3: Each measurement finishes within 50 microseconds of its write.
// RULE4: Completion sets a done flag; it drives interrupt only when unmasked.
// RULE5: Nine-bit result: low eight bits in one register, top bit in another.
// RULE6: Result is unsigned, 20 mA per step, all ones meaning 10.22 A.
// RULE7: Spread spectrum applies only when enabled and external sync is off.
// RULE8: Five-bit field holds expected external frequency, 1 to 24 MHz.
// RULE9: External clock valid only within ten percent of programmed frequency.
// RULE10: Sync off: detector idle, internal clock used, no clock events.
// RULE11: Sync on: detector runs, clock follows a valid external clock.
// RULE12: Sync on: valid clock appearing or vanishing sets a maskable flag.
// RULE13: Sync on: missing clock at otp-to-standby or standby-to-active flags. Sync is always off at otp load here; only standby-to-active flags.
// RULE14: Supply up: reset, load otp, open serial interface, enter standby.
// RULE15: Host waits 1.2 ms after supply rise before any access.
// RULE16: Converter settings are programmable with defaults loaded from otp.
// RULE17: Without forced PWM, heavy load runs PWM, light load PFM.
// RULE18: Forced PWM keeps fixed-frequency switching at any load.
// RULE19: Sync pin may be second output; both outputs open-drain or push-pull.
// RULE20: Switching clock source changes without runt pulses.
module buck_sync_clock_and_load_meas (
    input  wire logic                   CLK,
    input  wire logic                   NRST,
    input  wire logic                   WB_CYC_I,
    input  wire logic                   WB_STB_I,
    input  wire logic                   WB_WE_I,
    input  wire logic [7:0]             WB_ADR_I,
    input  wire logic [3:0]             WB_SEL_I,
    input  wire logic [31:0]            WB_DAT_I,
    output logic      [31:0]            WB_DAT_O,
    output logic                        WB_ACK_O,
    input  wire buck_clk_pkg::conv_cfg_t OTP_CONV0,
    input  wire buck_clk_pkg::conv_cfg_t OTP_CONV1,
    input  wire logic [8:0]             LOAD_CURRENT_CODE,
    input  wire logic [1:0]             HEAVY_LOAD,
    input  wire logic                   SYNC_PIN_IN,
    output logic                        SYNC_PIN_OUT,
    output logic                        SYNC_PIN_OE,
    output logic                        GPO_OUT,
    output logic                        GPO_OE,
    output logic [1:0]                  MODE_PWM,
    output logic [1:0]                  MEAS_ACTIVE,
    output logic                        SWITCH_CLK,
    output logic                        USING_EXT,
    output logic                        IRQ_N,
    output logic                        SERIAL_READY,
    output logic                        ACTIVE
);
    import buck_clk_pkg::*;

    pwr_state_t  state;
    logic [3:0]  ctrl;
    logic [4:0]  freq;
    conv_cfg_t   conv0;
    conv_cfg_t   conv1;
    logic [4:0]  general_digital_output;
    logic [1:0]  mask;
    logic [1:0]  flags;
    logic        meas_busy;
    logic        meas_sel;
    logic [11:0] meas_cnt;
    logic [11:0] busy_age;
    logic [8:0]  result;
    logic        meas_done;
    logic        ext_prev;
    logic        ext_rise;
    logic [9:0]  win_cnt;
    logic [8:0]  edge_cnt;
    logic        ext_valid;
    logic        ext_valid_q;
    logic        sel_ext;
    logic [2:0]  rc_cnt;
    logic [2:0]  rc_half;
    logic [1:0]  dither;
    logic        rc_clk;
    logic        bus_req;
    logic        bus_wr;
    logic        ext_en;
    logic        to_standby;
    logic        to_active;
    logic        sync_event;
    logic [31:0] next_rdata;
    logic [8:0]  lo_lim;
    logic [8:0]  hi_lim;
    logic        next_ext_valid;

    assign bus_req = WB_CYC_I && WB_STB_I && !WB_ACK_O;
    assign bus_wr  = bus_req && WB_WE_I && WB_SEL_I[0] && SERIAL_READY;
    assign ext_en  = ctrl[CTRL_EXT_SYNC];

    // Power-up sequencing
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            state <= ST_POR;
        end else begin
            case (state)
                ST_POR:      state <= ST_OTP_LOAD; // RULE14
                ST_OTP_LOAD: state <= ST_STANDBY;  // RULE14
                ST_STANDBY: begin
                    if (ctrl[CTRL_CONV_EN0+:2] != 2'b00) begin
                        state <= ST_ACTIVE;
                    end
                end
                ST_ACTIVE: begin
                    if (ctrl[CTRL_CONV_EN0+:2] == 2'b00) begin
                        state <= ST_STANDBY;
                    end
                end
                default: state <= ST_POR;
            endcase
        end
    end

    assign to_standby = (state == ST_OTP_LOAD);
    assign to_active  = (state == ST_STANDBY) &&
                        (ctrl[CTRL_CONV_EN0+:2] != 2'b00);
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            SERIAL_READY <= 1'b0;
            ACTIVE       <= 1'b0;
        end else begin
            SERIAL_READY <= (state == ST_OTP_LOAD) ||
                            (state == ST_STANDBY) ||
                            (state == ST_ACTIVE); // RULE14
            ACTIVE       <= to_active ||
                            ((state == ST_ACTIVE) &&
                             (ctrl[CTRL_CONV_EN0+:2] != 2'b00));
        end
    end

    // Register writes; converter defaults come from otp at load
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            ctrl  <= CTRL_RESET;
            freq  <= FREQ_RESET;
            general_digital_output   <= GPO_RESET;
            mask  <= MASK_RESET;
            conv0 <= '0;
            conv1 <= '0;
        end else if (state == ST_OTP_LOAD) begin
            conv0 <= OTP_CONV0; // RULE16
            conv1 <= OTP_CONV1; // RULE16
        end else if (bus_wr) begin
            case (WB_ADR_I)
                OFS_CTRL:   ctrl <= WB_DAT_I[3:0];
                OFS_CLKCFG: begin
                    if (WB_DAT_I[4:0] >= 5'(FREQ_MIN_MHZ) &&
                        WB_DAT_I[4:0] <= 5'(FREQ_MAX_MHZ)) begin
                        freq <= WB_DAT_I[4:0]; // RULE8
                    end
                end
                OFS_CONV0:  conv0 <= WB_DAT_I[21:0]; // RULE16
                OFS_CONV1:  conv1 <= WB_DAT_I[21:0]; // RULE16
                OFS_GPO:    general_digital_output <= WB_DAT_I[4:0];
                OFS_MASK:   mask <= WB_DAT_I[1:0];
                default:    ;
            endcase
        end
    end

    // Load-current measurement
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            meas_busy <= 1'b0;
            meas_sel  <= 1'b0;
            meas_cnt  <= '0;
            result    <= '0;
            busy_age  <= '0;
        end else if (bus_wr && WB_ADR_I == OFS_MEAS_SEL) begin
            meas_busy <= 1'b1; // RULE1
            meas_sel  <= WB_DAT_I[0]; // RULE1
            meas_cnt  <= '0;
            busy_age  <= '0;
        end else if (meas_busy) begin
            busy_age  <= busy_age + 12'h001;
            if (meas_cnt == 12'(MEAS_CYCLES - 1)) begin
                meas_busy <= 1'b0; // RULE3
                result    <= LOAD_CURRENT_CODE; // RULE6
            end else begin
                meas_cnt <= meas_cnt + 12'h001;
            end
        end
    end

    assign meas_done = meas_busy && (meas_cnt == 12'(MEAS_CYCLES - 1));
    // Converter mode: forced PWM, measurement, or load-based auto mode
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            MODE_PWM    <= 2'b00;
            MEAS_ACTIVE <= 2'b00;
        end else begin
            MODE_PWM[0] <= conv0.fpwm || HEAVY_LOAD[0] ||
                           (meas_busy && !meas_sel); // RULE2 RULE17 RULE18
            MODE_PWM[1] <= conv1.fpwm || HEAVY_LOAD[1] ||
                           (meas_busy && meas_sel); // RULE2 RULE17 RULE18
            MEAS_ACTIVE <= meas_busy ? (meas_sel ? 2'b10 : 2'b01) : 2'b00;
        end
    end

    // External clock detector: rising edges counted over a window
    assign ext_rise = SYNC_PIN_IN && !ext_prev;
    assign lo_lim   = 9'(freq * DET_WINDOW_US * (100 - TOL_PERCENT) / 100);
    assign hi_lim   = 9'(freq * DET_WINDOW_US * (100 + TOL_PERCENT) / 100);
    assign next_ext_valid = (edge_cnt >= lo_lim) && (edge_cnt <= hi_lim);

    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            ext_prev  <= 1'b0;
            win_cnt   <= '0;
            edge_cnt  <= '0;
            ext_valid <= 1'b0;
            ext_valid_q <= 1'b0;
        end else if (!ext_en || SYNC_PIN_OE) begin
            ext_valid_q <= ext_valid;
            ext_prev  <= 1'b0; // RULE10
            win_cnt   <= '0;
            edge_cnt  <= '0;
            ext_valid <= 1'b0; // RULE10
        end else begin
            ext_valid_q <= ext_valid;
            ext_prev <= SYNC_PIN_IN;
            if (win_cnt == 10'(DET_CYCLES - 1)) begin
                win_cnt   <= '0;
                edge_cnt  <= '0;
                ext_valid <= next_ext_valid; // RULE9 RULE11
            end else begin
                win_cnt <= win_cnt + 10'h001;
                if (ext_rise && edge_cnt != 9'h1ff) begin
                    edge_cnt <= edge_cnt + 9'h001;
                end
            end
        end
    end

    // Internal oscillator with optional dither of the half period
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            rc_cnt  <= '0;
            rc_clk  <= 1'b0;
            dither  <= '0;
            rc_half <= 3'(RC_HALF_NOM);
        end else if (rc_cnt == rc_half - 3'h1) begin
            rc_cnt <= '0;
            rc_clk <= !rc_clk;
            dither <= dither + 2'h1;
            if (ctrl[CTRL_SPREAD] && !ext_en) begin
                rc_half <= (dither == 2'h0) ? 3'(RC_HALF_MIN) :
                           (dither == 2'h2) ? 3'(RC_HALF_MAX) :
                           3'(RC_HALF_NOM); // RULE7
            end else begin
                rc_half <= 3'(RC_HALF_NOM); // RULE7
            end
        end else begin
            rc_cnt <= rc_cnt + 3'h1;
        end
    end

    // Source handoff only while both clocks are low
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            sel_ext    <= 1'b0;
            SWITCH_CLK <= 1'b0;
            USING_EXT  <= 1'b0;
        end else begin
            if (sel_ext != (ext_en && ext_valid) &&
                !rc_clk && !SYNC_PIN_IN) begin
                sel_ext <= ext_en && ext_valid; // RULE11 RULE20
            end
            SWITCH_CLK <= sel_ext ? SYNC_PIN_IN : rc_clk; // RULE20
            USING_EXT  <= sel_ext;
        end
    end

    // Event flags; a set in the clearing cycle wins
    assign sync_event = ext_en && ((ext_valid != ext_valid_q) ||
                        ((to_standby || to_active) && !ext_valid));

    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            flags <= 2'b00;
        end else begin
            if (meas_done) begin
                flags[FLAG_MEAS] <= 1'b1; // RULE4
            end else if (bus_wr && WB_ADR_I == OFS_FLAGS &&
                         WB_DAT_I[FLAG_MEAS]) begin
                flags[FLAG_MEAS] <= 1'b0;
            end
            if (sync_event) begin
                flags[FLAG_SYNC] <= 1'b1; // RULE12 RULE13
            end else if (bus_wr && WB_ADR_I == OFS_FLAGS &&
                         WB_DAT_I[FLAG_SYNC]) begin
                flags[FLAG_SYNC] <= 1'b0;
            end
        end
    end

    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            IRQ_N <= 1'b1;
        end else begin
            IRQ_N <= !((flags & ~mask) != 2'b00); // RULE4 RULE12
        end
    end

    // General outputs: open drain only pulls low
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            GPO_OUT      <= 1'b0;
            GPO_OE       <= 1'b0;
            SYNC_PIN_OUT <= 1'b0;
            SYNC_PIN_OE  <= 1'b0;
        end else begin
            GPO_OUT <= general_digital_output[GPO_VAL1] && !general_digital_output[GPO_OD1];
            GPO_OE  <= !general_digital_output[GPO_OD1] || !general_digital_output[GPO_VAL1]; // RULE19
            if (general_digital_output[GPO_PIN_AS_SECOND_GENERAL_OUTPUT] && !ext_en) begin
                SYNC_PIN_OUT <= general_digital_output[GPO_VAL2] && !general_digital_output[GPO_OD2];
                SYNC_PIN_OE  <= !general_digital_output[GPO_OD2] ||
                                !general_digital_output[GPO_VAL2]; // RULE19
            end else begin
                SYNC_PIN_OUT <= 1'b0;
                SYNC_PIN_OE  <= 1'b0;
            end
        end
    end

    // Read mux
    always_comb begin
        next_rdata = 32'h0000_0000;
        case (WB_ADR_I)
            OFS_CTRL:      next_rdata[3:0]  = ctrl;
            OFS_CLKCFG:    next_rdata[4:0]  = freq;
            OFS_CONV0:     next_rdata[21:0] = conv0;
            OFS_CONV1:     next_rdata[21:0] = conv1;
            OFS_GPO:       next_rdata[4:0]  = general_digital_output;
            OFS_MEAS_SEL:  next_rdata[0]    = meas_sel;
            OFS_RESULT_LO: next_rdata[7:0]  = result[7:0]; // RULE5
            OFS_RESULT_HI: next_rdata[0]    = result[8]; // RULE5
            OFS_FLAGS:     next_rdata[1:0]  = flags;
            OFS_MASK:      next_rdata[1:0]  = mask;
            OFS_STATUS:    next_rdata[3:0]  = {ACTIVE, sel_ext,
                                               ext_valid, meas_busy};
            default:       next_rdata = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            WB_ACK_O <= 1'b0;
            WB_DAT_O <= 32'h0000_0000;
        end else begin
            WB_ACK_O <= bus_req;
            WB_DAT_O <= (bus_req && SERIAL_READY) ? next_rdata
                                                  : 32'h0000_0000;
        end
    end

    default clocking cb @(posedge CLK); endclocking
    default disable iff (!NRST);

    sequence s_meas_start;
        bus_wr && WB_ADR_I == OFS_MEAS_SEL;
    endsequence
    sequence s_meas_run;
        meas_busy [*8];
    endsequence
    a_meas_starts: assert property (s_meas_start |=> meas_busy) // RULE1
        else $error("measurement did not start");
    a_meas_pwm: assert property (s_meas_start ##1 s_meas_run |=>
        MODE_PWM[meas_sel]) // RULE2
        else $error("measured converter not in PWM");
    a_meas_bound: assert property (meas_busy |->
        busy_age < 12'(MEAS_CYCLES)) // RULE3
        else $error("measurement exceeded 50 us");
    a_meas_flag: assert property (meas_done |=> flags[FLAG_MEAS]) // RULE4
        else $error("done flag not set");
    a_irq_masked: assert property ((flags & ~mask) == 2'b00 |=> IRQ_N) // RULE4
        else $error("masked flag drove interrupt");
    a_result_hold: assert property (meas_done |=>
        result == $past(LOAD_CURRENT_CODE)) // RULE5
        else $error("result not captured");
    a_spread_gate: assert property (ext_en && rc_cnt == rc_half - 3'h1 |=>
        rc_half == 3'(RC_HALF_NOM)) // RULE7
        else $error("dither with external sync");
    a_sync_off: assert property (!ext_en ##1 (!ext_en && !rc_clk &&
        !SYNC_PIN_IN) |=> !ext_valid && !sel_ext) // RULE10
        else $error("detector active with sync off");
    a_sync_flag: assert property (sync_event |=> flags[FLAG_SYNC]) // RULE12
        else $error("sync flag not set");
    a_otp_load: assert property (state == ST_OTP_LOAD |=>
        conv0 == $past(OTP_CONV0) && state == ST_STANDBY) // RULE14
        else $error("otp not loaded before standby");
    a_second_general_output_off: assert property (ext_en ##1 ext_en |-> !SYNC_PIN_OE) // RULE19
        else $error("sync pin driven while sync on");
    a_clk_switch: assert property ($changed(sel_ext) |->
        !$past(rc_clk) && !$past(SYNC_PIN_IN)) // RULE20
        else $error("clock source switched while high");

endmodule

// ### verification/sync_clock_source.sv
`timescale 1ns/1ps
module sync_clock_source (
    input  wire logic       clk,
    input  wire logic       nrst,
    input  wire logic       run,
    input  wire logic [3:0] half,
    input  wire logic       pin_oe,
    input  wire logic       pin_out,
    output logic            pin
);
    logic [3:0] cnt;
    logic       lvl;

    // Source stands still while stopped or while the pin is driven back
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            cnt <= 4'h0;
            lvl <= 1'b0;
        end else if (run && !pin_oe) begin
            if (cnt >= half - 4'h1) begin
                cnt <= 4'h0;
                lvl <= ~lvl;
            end else begin
                cnt <= cnt + 4'h1;
            end
        end
    end

    assign pin = pin_oe ? pin_out : lvl;
endmodule

// ### verification/buck_sync_clock_and_load_meas_tb_top.sv
`timescale 1ns/1ps
module buck_sync_clock_and_load_meas_tb_top;
    import buck_clk_pkg::*;
    localparam conv_cfg_t OTP0 = 22'h2b4c3c;
    localparam conv_cfg_t OTP1 = 22'h1e0277;
    logic        clk, nrst, cyc, stb, we, sync_pin, ext_run, ack, last_sw;
    logic        s_out, s_oe, g_out, g_oe, sw_clk, use_ext, irq_n, ready, act;
    logic [1:0]  heavy, mode_pwm, meas_act;
    logic [3:0]  sel, ext_half;
    logic [7:0]  adr;
    logic [8:0]  code;
    logic [31:0] wdat, dout, rd;
    logic [4:0]  gpo_val [6] = '{5'h01, 5'h05, 5'h04, 5'h12, 5'h1a, 5'h18};
    logic [3:0]  gpo_exp [6] = '{4'hc, 4'h0, 4'h8, 4'hb, 4'h8, 4'ha};
    int          errors, checks_done, run_len, n;
    bit          odd_run;

    buck_sync_clock_and_load_meas buck_sync_clock_and_load_meas_inst (
        .CLK               (clk),
        .NRST              (nrst),
        .WB_CYC_I          (cyc),
        .WB_STB_I          (stb),
        .WB_WE_I           (we),
        .WB_ADR_I          (adr),
        .WB_SEL_I          (sel),
        .WB_DAT_I          (wdat),
        .WB_DAT_O          (dout),
        .WB_ACK_O          (ack),
        .OTP_CONV0         (OTP0),
        .OTP_CONV1         (OTP1),
        .LOAD_CURRENT_CODE (code),
        .HEAVY_LOAD        (heavy),
        .SYNC_PIN_IN       (sync_pin),
        .SYNC_PIN_OUT      (s_out),
        .SYNC_PIN_OE       (s_oe),
        .GPO_OUT           (g_out),
        .GPO_OE            (g_oe),
        .MODE_PWM          (mode_pwm),
        .MEAS_ACTIVE       (meas_act),
        .SWITCH_CLK        (sw_clk),
        .USING_EXT         (use_ext),
        .IRQ_N             (irq_n),
        .SERIAL_READY      (ready),
        .ACTIVE            (act)
    );

    sync_clock_source sync_clock_source_inst (
        .clk     (clk),
        .nrst    (nrst),
        .run     (ext_run),
        .half    (ext_half),
        .pin_oe  (s_oe),
        .pin_out (s_out),
        .pin     (sync_pin)
    );

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    // Flags any switching-clock phase that is not the nominal length
    always @(posedge clk) begin
        if (sw_clk !== last_sw) begin
            if (run_len != RC_HALF_NOM)
                odd_run = 1'b1;
            run_len = 1;
        end else begin
            run_len++;
        end
        last_sw = sw_clk;
    end

    task automatic conclude;
        $display("errors=%0d checks_done=%0d", errors, checks_done);
        if (errors == 0 && checks_done > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
        int k;
        @(posedge clk);
        cyc  <= 1'b1;
        stb  <= 1'b1;
        we   <= w;
        adr  <= a;
        wdat <= d;
        k = 0;
        do begin
            @(posedge clk);
            k++;
        end while (ack !== 1'b1 && k < 20);
        rd = dout;
        cyc <= 1'b0;
        stb <= 1'b0;
        if (ack !== 1'b1) begin
            errors++;
            conclude();
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        wb(1'b1, a, d);
    endtask

    task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
        wb(1'b0, a, 32'h0);
        chk(rd, e);
    endtask

    task automatic spread(input logic [31:0] c, input logic e);
        wr(OFS_CTRL, c);
        repeat (60) @(posedge clk);
        odd_run = 1'b0;
        repeat (400) @(posedge clk);
        chk(odd_run, e);
    endtask

    task automatic wait_ext(input logic v);
        n = 0;
        while (use_ext !== v && n < 1600) begin
            @(posedge clk);
            n++;
        end
        if (use_ext !== v) begin
            errors++;
            conclude();
        end
    endtask

    initial begin
        nrst = 1'b0; cyc = 1'b0; stb = 1'b0; we = 1'b0; adr = 8'h0;
        wdat = 32'h0; sel = 4'hf; code = 9'h0; heavy = 2'h0;
        ext_run = 1'b0; ext_half = 4'h5; errors = 0; checks_done = 0;
        repeat (3) @(posedge clk);
        nrst <= 1'b1;
        repeat (60000) @(posedge clk);
        chk(ready, 1);
        chk(act, 0);
        rdchk(OFS_CTRL, 0);
        rdchk(OFS_CLKCFG, 1);
        rdchk(OFS_CONV0, {10'h0, OTP0});
        rdchk(OFS_CONV1, {10'h0, OTP1});
        rdchk(OFS_MASK, 0);
        rdchk(OFS_FLAGS, 0);
        wr(8'h30, 32'hff);
        rdchk(8'h30, 0);
        wr(OFS_CLKCFG, 24);
        rdchk(OFS_CLKCFG, 24);
        wr(OFS_CLKCFG, 25);
        wr(OFS_CLKCFG, 0);
        rdchk(OFS_CLKCFG, 24);
        chk(mode_pwm, 0);
        heavy <= 2'b10;
        repeat (3) @(posedge clk);
        chk(mode_pwm, 2);
        wr(OFS_CONV0, {10'h0, OTP0} | 32'h100);
        rdchk(OFS_CONV0, {10'h0, OTP0} | 32'h100);
        chk(mode_pwm, 3);
        heavy <= 2'b00;
        wr(OFS_CONV0, {10'h0, OTP0});
        repeat (3) @(posedge clk);
        chk(mode_pwm, 0);
        // Full-scale code on converter 1, flag unmasked
        code <= 9'h1ff;
        wr(OFS_MEAS_SEL, 1);
        repeat (2) @(posedge clk);
        chk(meas_act, 2);
        chk(mode_pwm, 2);
        n = 0;
        while (irq_n !== 1'b0 && n < 2510) begin
            @(posedge clk);
            n++;
        end
        chk(irq_n, 0);
        if (irq_n !== 1'b0) conclude();
        rdchk(OFS_RESULT_LO, 32'hff);
        rdchk(OFS_RESULT_HI, 1);
        rdchk(OFS_FLAGS, 1);
        chk(mode_pwm, 0);
        wr(OFS_FLAGS, 1);
        repeat (2) @(posedge clk);
        chk(irq_n, 1);
        // Masked completion on converter 0
        wr(OFS_MASK, 1);
        code <= 9'h0a5;
        wr(OFS_MEAS_SEL, 0);
        repeat (2) @(posedge clk);
        chk(meas_act, 1);
        chk(mode_pwm, 1);
        repeat (2510) @(posedge clk);
        chk(irq_n, 1);
        rdchk(OFS_FLAGS, 1);
        rdchk(OFS_RESULT_LO, 32'ha5);
        rdchk(OFS_RESULT_HI, 0);
        wr(OFS_FLAGS, 3);
        wr(OFS_MASK, 0);
        spread(0, 0);
        spread(2, 1);
        spread(3, 0);
        wr(OFS_CTRL, 0);
        wr(OFS_FLAGS, 3);
        // External clock at nominal rate, sync still off
        wr(OFS_CLKCFG, 5);
        ext_run <= 1'b1;
        repeat (1200) @(posedge clk);
        chk(use_ext, 0);
        rdchk(OFS_FLAGS, 0);
        wr(OFS_CTRL, 1);
        wait_ext(1'b1);
        chk(use_ext, 1);
        rdchk(OFS_STATUS, 6);
        rdchk(OFS_FLAGS, 2);
        chk(irq_n, 0);
        wr(OFS_FLAGS, 2);
        // About 17 percent slow: outside tolerance
        ext_half <= 4'h6;
        wait_ext(1'b0);
        chk(use_ext, 0);
        rdchk(OFS_FLAGS, 2);
        wr(OFS_MASK, 2);
        repeat (2) @(posedge clk);
        chk(irq_n, 1);
        wr(OFS_FLAGS, 2);
        wr(OFS_MASK, 0);
        ext_run <= 1'b0;
        wr(OFS_CTRL, 5);
        repeat (3) @(posedge clk);
        chk(act, 1);
        rdchk(OFS_FLAGS, 2);
        wr(OFS_CTRL, 0);
        for (int i = 0; i < 6; i++) begin
            wr(OFS_GPO, {27'h0, gpo_val[i]});
            repeat (2) @(posedge clk);
            chk({g_oe, g_out, s_oe, s_out}, gpo_exp[i]);
        end
        conclude();
    end
endmodule
